// *** include/irq_enable_pkg.sv ***
package irq_enable_pkg;

	// Geometry of the source banks.
	localparam int BANKS = 5;
	localparam int BANK_W = 16;
	localparam int PRIO_W = 3;
	localparam int ADDR_W = 6;
	localparam int PRIO_REGS = 20;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_STRIDE = 4;

	// Word offsets on the register port.
	localparam logic [5:0] ADDR_FLAG_BASE = 6'h00;
	localparam logic [5:0] ADDR_EN_BASE = 6'h08;
	localparam logic [5:0] ADDR_PRIO_BASE = 6'h10;
	localparam logic [5:0] ADDR_IRQ_STAT = 6'h28;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h29;
	localparam logic [5:0] ADDR_IRQ_CLR = 6'h2a;

	// Implemented bit positions of each bank, shared by flag and enable words.
	localparam logic [15:0] IMPL_MASK_0 = 16'h3fef;
	localparam logic [15:0] IMPL_MASK_1 = 16'hfe1f;
	localparam logic [15:0] IMPL_MASK_2 = 16'h22e3;
	localparam logic [15:0] IMPL_MASK_3 = 16'h4066;
	localparam logic [15:0] IMPL_MASK_4 = 16'h000e;

	// Reset values.
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam logic [15:0] EN_RESET = 16'h0000;
	localparam logic [2:0] PRIO_RESET = 3'h4;
	localparam logic [2:0] PRIO_OFF = 3'h0;
	localparam logic [4:0] IRQ_RESET = 5'h00;

	// One packed word per bank.
	typedef logic [BANKS-1:0][BANK_W-1:0] bank_word_t;
	typedef logic [BANKS-1:0][BANK_W-1:0][PRIO_W-1:0] prio_array_t;

	// One register port access as seen in a single cycle.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BANK_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_access_t;

endpackage : irq_enable_pkg

// *** tb/interrupt_enable_bank_bench.sv ***
`timescale 1ns/1ps
module interrupt_enable_bank_bench;
	logic coreClk = 1'b0;
	logic arstN = 1'b0;
	logic [5:0] regAddr = 6'h00;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic ce = 1'b1;
	logic [15:0] regRdata;
	logic [15:0] rdv;
	irq_enable_pkg::bank_word_t srcPulse;
	irq_enable_pkg::bank_word_t gatedReq;
	irq_enable_pkg::prio_array_t prioLevel;
	logic irqOut;
	int nErrors = 0;
	int nChecks = 0;

	// The clock flips every half period of 5 ns.
	always #5 coreClk = ~coreClk;

	interrupt_enable_bank u_dut (.core_clk(coreClk), .arst_n(arstN), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .srcPulse(srcPulse), .gatedReq(gatedReq),
		.prioLevel(prioLevel), .irqOut(irqOut));
	src_model u_src (.core_clk(coreClk), .srcPulse(srcPulse));

	function automatic logic [15:0] maskOf(input int b);
		case (b)
			0: return irq_enable_pkg::IMPL_MASK_0;
			1: return irq_enable_pkg::IMPL_MASK_1;
			2: return irq_enable_pkg::IMPL_MASK_2;
			3: return irq_enable_pkg::IMPL_MASK_3;
			default: return irq_enable_pkg::IMPL_MASK_4;
		endcase
	endfunction : maskOf

	task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One write cycle; the strobe drops at the next edge so strobes never overlap.
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge coreClk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge coreClk);
		regWr <= 1'b0;
	endtask : wr

	// Read data is registered at the edge after the strobe and held until the next read; it is taken just after that edge.
	task automatic rd(input logic [5:0] a);
		@(posedge coreClk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge coreClk);
		regRd <= 1'b0;
		#1;
		rdv = regRdata;
	endtask : rd

	task automatic testReset();
		for (int b = 0; b < 5; b++)
		begin
			rd(irq_enable_pkg::ADDR_EN_BASE + 6'(b));
			check("enable after reset", 80'(rdv), 80'h0);
		end
		check("gated after reset", gatedReq, 80'h0);
		check("priority after reset", 80'(prioLevel[0][0]), 80'h4);
		check("irq after reset", 80'(irqOut), 80'h0);
	endtask : testReset

	// Walks a single one through every position of every enable word.
	task automatic testBits();
		for (int b = 0; b < 5; b++)
		begin
			for (int i = 0; i < 16; i++)
			begin
				wr(irq_enable_pkg::ADDR_EN_BASE + 6'(b), 16'h0001 << i);
				rd(irq_enable_pkg::ADDR_EN_BASE + 6'(b));
				check("enable bit", 80'(rdv),
					80'((16'h0001 << i) & maskOf(b)));
			end
			wr(irq_enable_pkg::ADDR_EN_BASE + 6'(b), 16'hffff);
			rd(irq_enable_pkg::ADDR_EN_BASE + 6'(b));
			check("enable ones", 80'(rdv), 80'(maskOf(b)));
			wr(irq_enable_pkg::ADDR_EN_BASE + 6'(b), 16'h0000);
		end
		rd(6'h3f);
		check("unmapped read", 80'(rdv), 80'h0);
	endtask : testBits

	// Requests arrive while every source is disabled, then the enables open.
	task automatic testGate();
		logic [79:0] expV;
		u_src.fire('1);
		#1;
		check("gated while disabled", gatedReq, 80'h0);
		expV = '0;
		for (int b = 0; b < 5; b++)
		begin
			rd(irq_enable_pkg::ADDR_FLAG_BASE + 6'(b));
			check("flag word", 80'(rdv), 80'(maskOf(b)));
			wr(irq_enable_pkg::ADDR_EN_BASE + 6'(b), 16'ha5a5);
			expV[b*16 +: 16] = maskOf(b) & 16'ha5a5;
		end
		#1;
		check("gated after enable", gatedReq, expV);
	endtask : testGate

	// Status latches the gated requests until cleared; the output line obeys the irq enable.
	task automatic testIrq();
		rd(irq_enable_pkg::ADDR_IRQ_STAT);
		check("irq status", 80'(rdv), 80'h1f);
		check("irq masked", 80'(irqOut), 80'h0);
		wr(irq_enable_pkg::ADDR_IRQ_EN, 16'h0004);
		rd(irq_enable_pkg::ADDR_IRQ_EN);
		check("irq enable word", 80'(rdv), 80'h4);
		check("irq raised", 80'(irqOut), 80'h1);
		wr(irq_enable_pkg::ADDR_IRQ_EN, 16'h0000);
		rd(irq_enable_pkg::ADDR_IRQ_EN);
		check("irq dropped", 80'(irqOut), 80'h0);
		for (int b = 0; b < 5; b++)
			wr(irq_enable_pkg::ADDR_FLAG_BASE + 6'(b), 16'h0000);
		wr(irq_enable_pkg::ADDR_IRQ_CLR, 16'h001f);
		rd(irq_enable_pkg::ADDR_IRQ_STAT);
		check("status cleared", 80'(rdv), 80'h0);
		// Priority zero keeps the request visible but stops the status event.
		wr(irq_enable_pkg::ADDR_PRIO_BASE, 16'h0000);
		wr(irq_enable_pkg::ADDR_EN_BASE, 16'h000f);
		u_src.fire(80'h000f);
		rd(irq_enable_pkg::ADDR_IRQ_STAT);
		check("priority zero", 80'(prioLevel[0][0]), 80'h0);
		check("gated prio zero", 80'(gatedReq[0]), 80'h000f);
		check("status prio zero", 80'(rdv), 80'h0);
		// Word one of bank 0 holds an unimplemented source, which keeps its reset level.
		rd(irq_enable_pkg::ADDR_PRIO_BASE);
		check("priority word 0", 80'(rdv), 80'h0);
		rd(irq_enable_pkg::ADDR_PRIO_BASE + 6'h01);
		check("priority word 1", 80'(rdv), 80'h4444);
	endtask : testIrq

	// A write and a read on consecutive edges, as the bus allows.
	task automatic testBackToBack();
		@(posedge coreClk);
		regAddr <= irq_enable_pkg::ADDR_EN_BASE;
		regWdata <= 16'hffff;
		regWr <= 1'b1;
		@(posedge coreClk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge coreClk);
		regRd <= 1'b0;
		#1;
		check("write then read", 80'(regRdata), 80'(irq_enable_pkg::IMPL_MASK_0));
	endtask : testBackToBack

	// With the clock enable low a write and a request are both lost; then the gate opens.
	task automatic testHold();
		wr(irq_enable_pkg::ADDR_EN_BASE + 6'h03, 16'h4000);
		@(posedge coreClk);
		ce <= 1'b0;
		wr(irq_enable_pkg::ADDR_EN_BASE + 6'h03, 16'h0000);
		u_src.fire(80'h4000 << 48);
		@(posedge coreClk);
		ce <= 1'b1;
		rd(irq_enable_pkg::ADDR_EN_BASE + 6'h03);
		check("enable held while frozen", 80'(rdv), 80'h4000);
		check("no request while frozen", 80'(gatedReq[3]), 80'h0);
		u_src.fire(80'h4000 << 48);
		#1;
		check("request passed", 80'(gatedReq[3]), 80'h4000);
	endtask : testHold

	task automatic summarize();
		$display("checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// Main sequence after five cycles of reset.
	initial
	begin
		repeat (5) @(posedge coreClk);
		arstN <= 1'b1;
		testReset();
		testBits();
		testGate();
		testIrq();
		testBackToBack();
		testHold();
		summarize();
	end

	// The whole run takes about 440 cycles; a hang is cut far beyond that.
	initial
	begin
		repeat (20000) @(posedge coreClk);
		nErrors++;
		summarize();
	end
endmodule : interrupt_enable_bank_bench

// *** tb/src_model.sv ***
`timescale 1ns/1ps
// Stands in for the peripheral request sources on the far side of the block.
module src_model (
	input wire logic core_clk,
	output irq_enable_pkg::bank_word_t srcPulse
);
	initial srcPulse = '0;

	// A request lasts one whole cycle, so the block sees exactly one sampling edge.
	task automatic fire(input irq_enable_pkg::bank_word_t w);
		@(posedge core_clk);
		srcPulse <= w;
		@(posedge core_clk);
		srcPulse <= '0;
	endtask : fire
endmodule : src_model

// *** verilog/interrupt_enable_bank.sv ***
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - An enable bit at one passes its source request; at zero it blocks it.
// - Unimplemented bit positions of all enable words read back as zero.
// - Implemented enable bits are software read/write and clear at reset.
// - Enable word 0 bits 13 to 8 gate converter, serial1, sync serial1, timer3.
// - Enable word 0 bits 7-5, 3-0 gate timers, compare, capture, external 0.
// - Enable word 1 bits 15 to 9 gate serial2, external 2, timers, compares.
// - Enable word 1 bits 4 to 0 gate external 1, pin change, comparator, two-wire1.
// - Enable word 2 gates parallel port, compare5, captures, sync serial2 only.
// - Enable word 3 gates calendar, external 4 and 3, two-wire2 events only.
// - Enable word 4 bits 3 to 1 gate checksum engine and serial errors.
// - Each source has a flag set by its request, gated by its enable.
// - Each source has a three-bit priority; zero disables, seven is highest.
module interrupt_enable_bank (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire irq_enable_pkg::bank_word_t srcPulse,
	output irq_enable_pkg::bank_word_t gatedReq,
	output irq_enable_pkg::prio_array_t prioLevel,
	output logic irqOut
);

	// Implemented positions of one bank.
	function automatic logic [15:0] implMask(input int bank);
		logic [15:0] m;
		m = 16'h0000;
		unique case (bank)
			0: m = irq_enable_pkg::IMPL_MASK_0;
			1: m = irq_enable_pkg::IMPL_MASK_1;
			2: m = irq_enable_pkg::IMPL_MASK_2;
			3: m = irq_enable_pkg::IMPL_MASK_3;
			4: m = irq_enable_pkg::IMPL_MASK_4;
			default: m = 16'h0000;
		endcase
		return m;
	endfunction : implMask

	// True when the address falls inside a block of consecutive words.
	function automatic logic inRange(input logic [5:0] addr, input logic [5:0] base,
		input logic [5:0] count);
		return (addr >= base) && (addr < 6'(base + count));
	endfunction : inRange

	// Word index of the address inside its block.
	function automatic logic [4:0] wordIndex(input logic [5:0] addr, input logic [5:0] base);
		logic [5:0] diff;
		diff = 6'(addr - base);
		return diff[4:0];
	endfunction : wordIndex

	irq_enable_pkg::reg_access_t acc;
	irq_enable_pkg::bank_word_t flagQ;
	irq_enable_pkg::bank_word_t flagD;
	irq_enable_pkg::bank_word_t enQ;
	irq_enable_pkg::bank_word_t enD;
	irq_enable_pkg::prio_array_t prioQ;
	irq_enable_pkg::prio_array_t prioD;
	irq_enable_pkg::bank_word_t prioLive;
	logic [4:0] irqStatQ;
	logic [4:0] irqStatD;
	logic [4:0] irqEnQ;
	logic [4:0] irqEnD;
	logic [4:0] bankEvent;
	logic [15:0] rdataQ;
	logic [15:0] rdataD;
	logic isFlag;
	logic isEn;
	logic isPrio;
	logic [4:0] idx;

	// Collect the port signals of one access into a single carrier.
	assign acc = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	assign isFlag = inRange(acc.addr, irq_enable_pkg::ADDR_FLAG_BASE, 6'h05);
	assign isEn = inRange(acc.addr, irq_enable_pkg::ADDR_EN_BASE, 6'h05);
	assign isPrio = inRange(acc.addr, irq_enable_pkg::ADDR_PRIO_BASE, 6'h14);
	assign idx = isFlag ? wordIndex(acc.addr, irq_enable_pkg::ADDR_FLAG_BASE) :
		isEn ? wordIndex(acc.addr, irq_enable_pkg::ADDR_EN_BASE) :
		wordIndex(acc.addr, irq_enable_pkg::ADDR_PRIO_BASE);

	// Per-bank gating and event detection; combinational so a set flag costs no further latency.
	for (genvar b = 0; b < irq_enable_pkg::BANKS; b++)
	begin : g_bank
		for (genvar s = 0; s < irq_enable_pkg::BANK_W; s++)
		begin : g_src
			assign prioLive[b][s] = (prioQ[b][s] != irq_enable_pkg::PRIO_OFF);
		end
		assign gatedReq[b] = flagQ[b] & enQ[b];
		assign bankEvent[b] = |(gatedReq[b] & prioLive[b]);
	end

	// Next values of flags, enables and priorities.
	always_comb
	begin
		int pb;
		int ps;
		flagD = flagQ;
		enD = enQ;
		prioD = prioQ;
		pb = 0;
		ps = 0;
		if (acc.wr && isFlag)
		begin
			flagD[idx] = acc.wdata;
		end
		if (acc.wr && isEn)
		begin
			enD[idx] = acc.wdata;
		end
		if (acc.wr && isPrio)
		begin
			pb = int'(idx) / irq_enable_pkg::FIELDS_PER_REG;
			for (int k = 0; k < irq_enable_pkg::FIELDS_PER_REG; k++)
			begin
				ps = (int'(idx) % irq_enable_pkg::FIELDS_PER_REG) * 4 + k;
				if (|(implMask(pb) & (16'h0001 << ps)))
				begin
					prioD[pb][ps] = acc.wdata[k*irq_enable_pkg::FIELD_STRIDE +: 3];
				end
			end
		end
		for (int b = 0; b < irq_enable_pkg::BANKS; b++)
		begin
			// A request arriving with a software clear still leaves the flag set.
			flagD[b] = (flagD[b] | srcPulse[b]) & implMask(b);
			enD[b] = enD[b] & implMask(b);
		end
	end

	// Source state; the clock enable holds everything still.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int b = 0; b < irq_enable_pkg::BANKS; b++)
			begin
				flagQ[b] <= irq_enable_pkg::FLAG_RESET;
				enQ[b] <= irq_enable_pkg::EN_RESET;
				for (int s = 0; s < irq_enable_pkg::BANK_W; s++)
				begin
					prioQ[b][s] <= irq_enable_pkg::PRIO_RESET;
				end
			end
		end
		else if (ce)
		begin
			flagQ <= flagD;
			enQ <= enD;
			prioQ <= prioD;
		end
	end

	// Sticky per-bank interrupt status; a live event beats a same-cycle clear.
	always_comb
	begin
		irqStatD = irqStatQ;
		irqEnD = irqEnQ;
		if (acc.wr && (acc.addr == irq_enable_pkg::ADDR_IRQ_CLR))
		begin
			irqStatD = irqStatQ & ~acc.wdata[4:0];
		end
		if (acc.wr && (acc.addr == irq_enable_pkg::ADDR_IRQ_EN))
		begin
			irqEnD = acc.wdata[4:0];
		end
		irqStatD = irqStatD | bankEvent;
	end

	// Interrupt status and mask registers.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqStatQ <= irq_enable_pkg::IRQ_RESET;
			irqEnQ <= irq_enable_pkg::IRQ_RESET;
		end
		else if (ce)
		begin
			irqStatQ <= irqStatD;
			irqEnQ <= irqEnD;
		end
	end

	assign irqOut = |(irqStatQ & irqEnQ);
	assign prioLevel = prioQ;

	// Read data; unmapped and write-only words answer zero.
	always_comb
	begin
		int pb;
		int ps;
		rdataD = rdataQ;
		pb = 0;
		ps = 0;
		if (acc.rd)
		begin
			rdataD = 16'h0000;
			if (isFlag)
			begin
				rdataD = flagQ[idx];
			end
			else if (isEn)
			begin
				rdataD = enQ[idx] & implMask(int'(idx));
			end
			else if (isPrio)
			begin
				pb = int'(idx) / irq_enable_pkg::FIELDS_PER_REG;
				for (int k = 0; k < irq_enable_pkg::FIELDS_PER_REG; k++)
				begin
					ps = (int'(idx) % irq_enable_pkg::FIELDS_PER_REG) * 4 + k;
					rdataD[k*irq_enable_pkg::FIELD_STRIDE +: 3] = prioQ[pb][ps];
				end
			end
			else if (acc.addr == irq_enable_pkg::ADDR_IRQ_STAT)
			begin
				rdataD = {11'h000, irqStatQ};
			end
			else if (acc.addr == irq_enable_pkg::ADDR_IRQ_EN)
			begin
				rdataD = {11'h000, irqEnQ};
			end
		end
	end

	// Read data register; it holds its value until the next read.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdataQ <= 16'h0000;
		end
		else if (ce)
		begin
			rdataQ <= rdataD;
		end
	end

	assign regRdata = rdataQ;

	// Checks.
	sequence s_en0_write;
		ce && regWr && (regAddr == irq_enable_pkg::ADDR_EN_BASE);
	endsequence

	sequence s_en0_read;
		ce && regRd && (regAddr == irq_enable_pkg::ADDR_EN_BASE);
	endsequence

	property p_en_readback;
		@(posedge core_clk) disable iff (!arst_n)
		s_en0_write ##1 s_en0_read ##1 ce |->
			regRdata == ($past(regWdata, 2) & irq_enable_pkg::IMPL_MASK_0);
	endproperty
	a_en_readback: assert property (p_en_readback)
		else $error("Enable word 0 did not read back what was written.");

	property p_unimpl_zero;
		@(posedge core_clk) disable iff (!arst_n)
		ce && regRd && (regAddr == 6'h0a) |=> (regRdata & ~irq_enable_pkg::IMPL_MASK_2) == 16'h0000;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero)
		else $error("Unimplemented enable bits read as nonzero.");

	property p_unimpl_write;
		@(posedge core_clk) disable iff (!arst_n)
		s_en0_write and ((regWdata & irq_enable_pkg::IMPL_MASK_0) == 16'h0000) |=>
			enQ[0] == 16'h0000;
	endproperty
	a_unimpl_write: assert property (p_unimpl_write)
		else $error("Write to unimplemented enable bits changed state.");

	for (genvar b = 0; b < irq_enable_pkg::BANKS; b++)
	begin : g_chk
		property p_bank_mask;
			@(posedge core_clk) disable iff (!arst_n)
			ce && regWr |=> (enQ[b] & ~implMask(b)) == 16'h0000;
		endproperty
		a_bank_mask: assert property (p_bank_mask)
			else $error("Enable bit stored at an unimplemented position.");
	end

	property p_flag_set;
		@(posedge core_clk) disable iff (!arst_n)
		ce && srcPulse[1][4] |=> flagQ[1][4];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Source request did not set its flag.");

	property p_gate_pass;
		@(posedge core_clk) disable iff (!arst_n)
		ce && srcPulse[3][14] && enQ[3][14] && !regWr |=> gatedReq[3][14];
	endproperty
	a_gate_pass: assert property (p_gate_pass)
		else $error("Enabled request was not passed on.");

	property p_gate_block;
		@(posedge core_clk) disable iff (!arst_n)
		!enQ[0][0] |-> !gatedReq[0][0];
	endproperty
	a_gate_block: assert property (p_gate_block)
		else $error("Disabled request leaked to the priority logic.");

	property p_prio_write;
		@(posedge core_clk) disable iff (!arst_n)
		ce && regWr && (regAddr == irq_enable_pkg::ADDR_PRIO_BASE) |=>
			prioQ[0][0] == $past(regWdata[2:0]);
	endproperty
	a_prio_write: assert property (p_prio_write)
		else $error("Priority field did not take the written value.");

	property p_freeze;
		@(posedge core_clk) disable iff (!arst_n)
		!ce |=> $stable(enQ) && $stable(flagQ) && $stable(irqStatQ);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("State changed while the clock enable was low.");

	property p_set_beats_clear;
		@(posedge core_clk) disable iff (!arst_n)
		ce && bankEvent[0] |=> irqStatQ[0] ##0 (!irqEnQ[0] || irqOut);
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("Live event lost its sticky status bit.");

endmodule : interrupt_enable_bank
